// >>> include/tsd_consts.vh
`ifndef TSD_CONSTS_VH
`define TSD_CONSTS_VH

// processor status register numbers
`define TSD_REG_BOOT_STATUS 8'h03
`define TSD_REG_SECURITY 8'h05
`define TSD_REG_OSC_CTRL 8'h06
`define TSD_REG_CNT_TILE_CELL 8'h07
`define TSD_REG_CNT_TILE_WIRE 8'h08
`define TSD_REG_CNT_PERIPH_CELL 8'h09
`define TSD_REG_CNT_PERIPH_WIRE 8'h0a
`define TSD_REG_DBG_STATUS 8'h10
`define TSD_REG_DBG_PC 8'h11
`define TSD_REG_DBG_SP 8'h12
`define TSD_REG_DBG_CORE_SEL 8'h13
`define TSD_REG_DBG_REG_SEL 8'h14
`define TSD_REG_DBG_CAUSE 8'h15
`define TSD_REG_DBG_INFO 8'h16

// boot status fields
`define TSD_BOOT_TILE_LSB 16
`define TSD_BOOT_OTP_BIT 8

// oscillator control fields
`define TSD_OSC_TILE_BIT 1
`define TSD_OSC_PERIPH_BIT 0
`define TSD_OSC_CTRL_RESET 2'h0

// debug cause register fields
`define TSD_CAUSE_CODE_LSB 0
`define TSD_CAUSE_CORE_LSB 8
`define TSD_CAUSE_TRIG_LSB 16
`define TSD_CAUSE_RESET 3'h0

// debug cause codes
`define TSD_CAUSE_NONE 3'h0
`define TSD_CAUSE_JTAG 3'h1
`define TSD_CAUSE_TRAP 3'h2
`define TSD_CAUSE_IBRK 3'h3
`define TSD_CAUSE_DWATCH 3'h4
`define TSD_CAUSE_RWATCH 3'h5

// ring oscillator counter width
`define TSD_CNT_W 16
// power-up count for simulation; silicon starts wherever the flops land
`define TSD_CNT_POWERUP 16'h0000

`endif

// >>> hdl/tsd_ring_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "tsd_consts.vh"

// counter clocked by a free-running ring oscillator, no reset on purpose
module tsd_ring_counter (
  input wire osc_clk,
  input wire run,
  output reg [`TSD_CNT_W-1:0] count = `TSD_CNT_POWERUP
);

  // enable is sampled in the oscillator domain; software stops before reading
  reg run_meta;
  reg run_sync;

  always @(posedge osc_clk) begin // R8
    run_meta <= run;
    run_sync <= run_meta;
  end

  // no reset term: the count survives a system reset
  always @(posedge osc_clk) begin // R10
    if (run_sync) begin // R5
      count <= count + 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/tsd_status_regs.v
//Function
// R1 - boot status 23:16 reports switch tile number
// R2 - boot status bit 8 flags otp boot
// R3 - boot status 7:0 show boot pins
// R4 - security register returns otp word read-only
// R5 - four ring oscillators each drive counters
// R6 - control bit1 tile, bit0 peripheral oscillators
// R7 - software reads counters only when stopped
// R8 - oscillators asynchronous to tile clock
// R9 - registers 0x07-0x0a give 16-bit counts
// R10 - counters not cleared by system reset
// R11 - debug entry captures status word
// R12 - debug entry captures pc and sp
// R13 - core select operand in bits 7:0
// R14 - register select operand in bits 4:0
// R15 - cause code bits 2:0, reset zero
// R16 - lowest trigger number in bits 17:16
// R17 - causing core in bits 15:8
// R18 - info captures address or resource id
// R19 - software forms resource id reg<<8 | 0x0c
// R20 - read-only writes ignored, reserved bits zero
`timescale 1ns/1ps
`default_nettype none
`include "tsd_consts.vh"

module tsd_status_regs (
  input wire clk,
  input wire rst_n,
  // processor status access, one request per cycle
  input wire ps_read,
  input wire ps_write,
  input wire [7:0] ps_reg,
  input wire [31:0] ps_wdata,
  input wire debug_mode,
  output reg [31:0] ps_rdata,
  output reg ps_rvalid,
  // strap and otp inputs, held stable by the system
  input wire [7:0] tile_switch_id,
  input wire otp_boot_enable,
  input wire [7:0] boot_select_pins,
  input wire [31:0] otp_security_word,
  // debugger entry event
  input wire debug_enter,
  input wire [31:0] saved_status_word,
  input wire [31:0] saved_program_counter,
  input wire [31:0] saved_stack_pointer,
  input wire [2:0] enter_cause,
  input wire [7:0] enter_core,
  input wire [3:0] enter_trigger_hits,
  input wire [31:0] enter_info,
  // ring oscillator clocks
  input wire osc_tile_cell,
  input wire osc_tile_wire,
  input wire osc_periph_cell,
  input wire osc_periph_wire,
  output reg tile_osc_enable,
  output reg periph_osc_enable,
  // operands for the debug register fetch
  output reg [7:0] debug_fetch_core,
  output reg [4:0] debug_fetch_reg
);

  reg [31:0] dbg_status;
  reg [31:0] dbg_pc;
  reg [31:0] dbg_sp;
  reg [2:0] cause_code;
  reg [7:0] cause_core;
  reg [1:0] cause_trigger;
  reg [31:0] dbg_info;
  reg [31:0] next_rdata;
  wire [`TSD_CNT_W-1:0] cnt_tile_cell;
  wire [`TSD_CNT_W-1:0] cnt_tile_wire;
  wire [`TSD_CNT_W-1:0] cnt_periph_cell;
  wire [`TSD_CNT_W-1:0] cnt_periph_wire;
  wire wr_dbg;
  wire wr_osc_ctrl;
  wire wr_dbg_pc;
  wire wr_dbg_sp;
  wire wr_core_sel;
  wire wr_reg_sel;
  wire wr_cause;
  wire wr_info;
  wire capture_trigger;
  wire capture_info;

  // lowest set bit wins when several triggers fire together
  function [1:0] lowest_hit;
    input [3:0] hits;
    begin
      if (hits[0]) begin
        lowest_hit = 2'h0;
      end else if (hits[1]) begin
        lowest_hit = 2'h1;
      end else if (hits[2]) begin
        lowest_hit = 2'h2;
      end else if (hits[3]) begin
        lowest_hit = 2'h3;
      end else begin
        lowest_hit = 2'h0;
      end
    end
  endfunction

  function is_watch_cause;
    input [2:0] code;
    begin
      is_watch_cause = (code == `TSD_CAUSE_IBRK) || (code == `TSD_CAUSE_DWATCH) ||
                       (code == `TSD_CAUSE_RWATCH);
    end
  endfunction

  // one register number, qualified by its request strobe
  function write_hit;
    input req;
    input [7:0] num;
    input [7:0] target;
    begin
      write_hit = req && (num == target);
    end
  endfunction

  // counts are 16 bits wide; the upper half of the word stays zero
  function [31:0] count_word;
    input [`TSD_CNT_W-1:0] cnt;
    begin
      count_word = 32'h0;
      count_word[`TSD_CNT_W-1:0] = cnt;
    end
  endfunction

  // debug registers only take writes from debug code
  assign wr_dbg = ps_write && debug_mode;
  assign wr_osc_ctrl = write_hit(ps_write, ps_reg, `TSD_REG_OSC_CTRL);
  assign wr_dbg_pc = write_hit(wr_dbg, ps_reg, `TSD_REG_DBG_PC);
  assign wr_dbg_sp = write_hit(wr_dbg, ps_reg, `TSD_REG_DBG_SP);
  assign wr_core_sel = write_hit(wr_dbg, ps_reg, `TSD_REG_DBG_CORE_SEL);
  assign wr_reg_sel = write_hit(wr_dbg, ps_reg, `TSD_REG_DBG_REG_SEL);
  assign wr_cause = write_hit(wr_dbg, ps_reg, `TSD_REG_DBG_CAUSE);
  assign wr_info = write_hit(wr_dbg, ps_reg, `TSD_REG_DBG_INFO);

  // the trigger number means something only for break and watch causes
  assign capture_trigger = is_watch_cause(enter_cause);
  assign capture_info = (enter_cause == `TSD_CAUSE_DWATCH) ||
                        (enter_cause == `TSD_CAUSE_RWATCH);

  tsd_ring_counter u_cnt_tile_cell (
    .osc_clk(osc_tile_cell),
    .run(tile_osc_enable),
    .count(cnt_tile_cell)
  ); // R5

  tsd_ring_counter u_cnt_tile_wire (
    .osc_clk(osc_tile_wire),
    .run(tile_osc_enable),
    .count(cnt_tile_wire)
  );

  tsd_ring_counter u_cnt_periph_cell (
    .osc_clk(osc_periph_cell),
    .run(periph_osc_enable),
    .count(cnt_periph_cell)
  );

  tsd_ring_counter u_cnt_periph_wire (
    .osc_clk(osc_periph_wire),
    .run(periph_osc_enable),
    .count(cnt_periph_wire)
  );

  // both enables follow one write, in any mode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tile_osc_enable <= 1'b0;
    end else if (wr_osc_ctrl) begin
      tile_osc_enable <= ps_wdata[`TSD_OSC_TILE_BIT]; // R6
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      periph_osc_enable <= 1'b0;
    end else if (wr_osc_ctrl) begin
      periph_osc_enable <= ps_wdata[`TSD_OSC_PERIPH_BIT]; // R6
    end
  end

  // debug entry beats a same-cycle software write in the pc, sp, cause and info blocks; status takes no software write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_status <= 32'h0;
    end else if (debug_enter) begin
      dbg_status <= saved_status_word; // R11
    end
  end

  // debug code may rewrite the saved pc before it returns
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_pc <= 32'h0;
    end else if (debug_enter) begin
      dbg_pc <= saved_program_counter; // R12
    end else if (wr_dbg_pc) begin
      dbg_pc <= ps_wdata; // R12
    end
  end

  // the saved stack pointer follows the same rules as the saved pc
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_sp <= 32'h0;
    end else if (debug_enter) begin
      dbg_sp <= saved_stack_pointer; // R12
    end else if (wr_dbg_sp) begin
      dbg_sp <= ps_wdata;
    end
  end

  // code, core and trigger fields are written together as one word
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_code <= `TSD_CAUSE_RESET;
      cause_core <= 8'h0;
      cause_trigger <= 2'h0;
    end else if (debug_enter) begin
      cause_code <= enter_cause; // R15
      cause_core <= enter_core; // R17
      if (capture_trigger) begin
        cause_trigger <= lowest_hit(enter_trigger_hits); // R16
      end else begin
        cause_trigger <= 2'h0;
      end
    end else if (wr_cause) begin
      cause_code <= ps_wdata[`TSD_CAUSE_CODE_LSB +: 3]; // R20
      cause_core <= ps_wdata[`TSD_CAUSE_CORE_LSB +: 8];
      cause_trigger <= ps_wdata[`TSD_CAUSE_TRIG_LSB +: 2];
    end
  end

  // other causes keep the last address or resource id
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_info <= 32'h0;
    end else if (debug_enter) begin
      if (capture_info) begin
        dbg_info <= enter_info; // R18
      end
    end else if (wr_info) begin
      dbg_info <= ps_wdata;
    end
  end

  // the operands feed the debug register fetch straight from these flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_fetch_core <= 8'h0;
    end else if (wr_core_sel) begin
      debug_fetch_core <= ps_wdata[7:0]; // R13
    end
  end

  // only bits 4:0 are kept; the rest reads back as zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_fetch_reg <= 5'h0;
    end else if (wr_reg_sel) begin
      debug_fetch_reg <= ps_wdata[4:0]; // R14
    end
  end

  // read mux; unmapped numbers and reserved bits return zero
  always @* begin
    next_rdata = 32'h0;
    case (ps_reg)
      `TSD_REG_BOOT_STATUS: begin
        next_rdata[`TSD_BOOT_TILE_LSB +: 8] = tile_switch_id; // R1
        next_rdata[`TSD_BOOT_OTP_BIT] = otp_boot_enable; // R2
        next_rdata[7:0] = boot_select_pins; // R3
      end
      `TSD_REG_SECURITY: begin
        next_rdata = otp_security_word; // R4
      end
      `TSD_REG_OSC_CTRL: begin
        next_rdata[`TSD_OSC_TILE_BIT] = tile_osc_enable;
        next_rdata[`TSD_OSC_PERIPH_BIT] = periph_osc_enable;
      end
      // counts cross domains unsynchronised; valid only with oscillators stopped
      `TSD_REG_CNT_TILE_CELL: begin
        next_rdata = count_word(cnt_tile_cell); // R9
      end
      `TSD_REG_CNT_TILE_WIRE: begin
        next_rdata = count_word(cnt_tile_wire); // R9
      end
      `TSD_REG_CNT_PERIPH_CELL: begin
        next_rdata = count_word(cnt_periph_cell); // R9
      end
      `TSD_REG_CNT_PERIPH_WIRE: begin
        next_rdata = count_word(cnt_periph_wire); // R9
      end
      `TSD_REG_DBG_STATUS: begin
        next_rdata = dbg_status;
      end
      `TSD_REG_DBG_PC: begin
        next_rdata = dbg_pc;
      end
      `TSD_REG_DBG_SP: begin
        next_rdata = dbg_sp;
      end
      `TSD_REG_DBG_CORE_SEL: begin
        next_rdata[7:0] = debug_fetch_core;
      end
      `TSD_REG_DBG_REG_SEL: begin
        next_rdata[4:0] = debug_fetch_reg;
      end
      `TSD_REG_DBG_CAUSE: begin
        next_rdata[`TSD_CAUSE_CODE_LSB +: 3] = cause_code;
        next_rdata[`TSD_CAUSE_CORE_LSB +: 8] = cause_core;
        next_rdata[`TSD_CAUSE_TRIG_LSB +: 2] = cause_trigger;
      end
      `TSD_REG_DBG_INFO: begin
        next_rdata = dbg_info;
      end
      default: begin
        next_rdata = 32'h0; // R20
      end
    endcase
  end

  // one-cycle answer strobe, one cycle after the request
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ps_rvalid <= 1'b0;
    end else begin
      ps_rvalid <= ps_read;
    end
  end

  // read data holds until the next read, so a slow consumer can still take it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ps_rdata <= 32'h0;
    end else if (ps_read) begin
      ps_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// >>> tb/tsd_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tsd_status_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ps_read,
  input wire logic ps_write,
  input wire logic [7:0] ps_reg,
  input wire logic [31:0] ps_wdata,
  input wire logic debug_mode,
  input wire logic [31:0] ps_rdata,
  input wire logic ps_rvalid,
  input wire logic [7:0] tile_switch_id,
  input wire logic otp_boot_enable,
  input wire logic [7:0] boot_select_pins,
  input wire logic [31:0] otp_security_word,
  input wire logic debug_enter,
  input wire logic [31:0] saved_program_counter,
  input wire logic [2:0] enter_cause,
  input wire logic [7:0] enter_core,
  input wire logic tile_osc_enable,
  input wire logic periph_osc_enable,
  input wire logic [7:0] debug_fetch_core
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(logic [7:0] r);
    ps_read && ps_reg == r;
  endsequence
  // capture and read-back are separate steps, so the captured values ride in locals
  property p_cause;
    logic [2:0] c;
    logic [7:0] k;
    (debug_enter, c = enter_cause, k = enter_core) ##[1:4] s_rd(8'h15)
      |=> ps_rdata[15:0] == {k, 5'h00, c};
  endproperty
  property p_pc;
    logic [31:0] p;
    (debug_enter, p = saved_program_counter) ##[1:4] s_rd(8'h11) |=> ps_rdata == p;
  endproperty
  property p_osc;
    logic [1:0] v;
    (ps_write && ps_reg == 8'h06, v = ps_wdata[1:0])
      |=> {tile_osc_enable, periph_osc_enable} == v;
  endproperty
  property p_core;
    logic [7:0] v;
    (debug_mode && ps_write && ps_reg == 8'h13, v = ps_wdata[7:0]) |=> debug_fetch_core == v;
  endproperty
  chk_read_answered: assert property (ps_read |=> ps_rvalid)
    else $error("read not answered");
  chk_boot_fields: assert property (s_rd(8'h03) |=> ps_rdata == {8'h00, $past(tile_switch_id),
    7'h00, $past(otp_boot_enable), $past(boot_select_pins)}) else $error("boot word wrong");
  chk_security_copy: assert property (s_rd(8'h05) |=> ps_rdata == $past(otp_security_word))
    else $error("security word wrong");
  chk_count_upper_zero: assert property (ps_read && ps_reg inside {[8'h07:8'h0a]}
    |=> ps_rdata[31:16] == 16'h0000) else $error("count upper bits set");
  chk_reg_sel_reserved: assert property (s_rd(8'h14) |=> ps_rdata[31:5] == 27'h0)
    else $error("reserved bits set");
  chk_osc_control: assert property (p_osc) else $error("osc enables wrong");
  chk_core_select: assert property (p_core) else $error("core select wrong");
  chk_cause_capture: assert property (p_cause) else $error("cause wrong");
  chk_pc_capture: assert property (p_pc) else $error("saved pc wrong");
endmodule
bind tsd_status_regs tsd_status_asserts u_chk (.*);
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, ps_read = 0, ps_write = 0, debug_mode = 0, debug_enter = 0;
  logic [7:0] ps_reg = 0, tile_switch_id = 8'h5a, boot_select_pins = 8'hc3, enter_core = 0;
  logic otp_boot_enable = 1, o0 = 0, o1 = 0, o2 = 0, o3 = 0;
  logic [31:0] ps_wdata = 0, otp_security_word = 32'h1234abcd, enter_info = 0;
  logic [31:0] saved_status_word = 0, saved_program_counter = 0, saved_stack_pointer = 0;
  logic [2:0] enter_cause = 0;
  logic [3:0] enter_trigger_hits = 4'b1100;
  logic [31:0] ps_rdata, q;
  logic [31:0] a [4];
  logic ps_rvalid, tile_osc_enable, periph_osc_enable;
  logic [7:0] debug_fetch_core;
  logic [4:0] debug_fetch_reg;
  int n_errors = 0, comparisons = 0;
  always #25 clk = ~clk;
  // oscillator half-periods chosen coprime to the tile clock half-period
  always #7 o0 = ~o0;
  always #11 o1 = ~o1;
  always #13 o2 = ~o2;
  always #17 o3 = ~o3;
  tsd_status_regs dut (.osc_tile_cell(o0), .osc_tile_wire(o1), .osc_periph_cell(o2),
    .osc_periph_wire(o3), .*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] r, input logic [31:0] d);
    logic [15:0] rid;
    rid = {r, 8'h0c};
    @(posedge clk);
    ps_write <= 1;
    ps_reg <= rid[15:8];
    ps_wdata <= d;
    @(posedge clk);
    ps_write <= 0;
    #1;
  endtask
  task automatic rd(input logic [7:0] r, output logic [31:0] v);
    logic [15:0] rid;
    rid = {r, 8'h0c};
    @(posedge clk);
    ps_read <= 1;
    ps_reg <= rid[15:8];
    @(posedge clk);
    ps_read <= 0;
    #1;
    chk(ps_rvalid, 1);
    v = ps_rdata;
  endtask
  task automatic rc(input logic [7:0] r, input logic [31:0] exp);
    rd(r, q);
    chk(q, exp);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    chk({tile_osc_enable, periph_osc_enable}, 0);
    rst_n <= 1;
    rc(8'h03, 32'h005a01c3);
    @(posedge clk);
    otp_boot_enable <= 0;
    boot_select_pins <= 8'h3c;
    rc(8'h03, 32'h005a003c);
    wr(8'h05, 0);
    rc(8'h05, 32'h1234abcd);
    rc(8'h04, 0);
    for (int d = 0; d < 4; d++) begin
      wr(8'h06, 32'hfffffffc | d);
      chk({tile_osc_enable, periph_osc_enable}, d);
      rc(8'h06, d);
    end
    repeat (20) @(posedge clk);
    wr(8'h06, 0);
    repeat (5) @(posedge clk);
    for (int i = 0; i < 4; i++) rd(8'h07 + i, a[i]);
    repeat (10) @(posedge clk);
    rst_n <= 0;
    @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 4; i++) rc(8'h07 + i, a[i]);
    wr(8'h06, 3);
    repeat (20) @(posedge clk);
    wr(8'h06, 0);
    repeat (5) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rd(8'h07 + i, q);
      chk(q !== a[i], 1);
    end
    for (int c = 1; c < 6; c++) begin
      @(posedge clk);
      debug_enter <= 1;
      enter_cause <= 3'(c);
      enter_core <= 8'(c * 3);
      saved_status_word <= 32'h11110000 + c;
      saved_program_counter <= 32'h22220000 + c;
      saved_stack_pointer <= 32'h33330000 + c;
      enter_info <= 32'h44440000 + c;
      @(posedge clk);
      debug_enter <= 0;
      rc(8'h11, 32'h22220000 + c);
      rc(8'h15, {14'h0, c > 2 ? 2'd2 : 2'd0, 8'(c * 3), 5'h0, 3'(c)});
      rc(8'h10, 32'h11110000 + c);
      rc(8'h12, 32'h33330000 + c);
      if (c > 3) rc(8'h16, 32'h44440000 + c);
    end
    wr(8'h11, 0);
    rc(8'h11, 32'h22220005);
    @(posedge clk);
    debug_mode <= 1;
    wr(8'h13, 32'hffffffff);
    rc(8'h13, 32'hff);
    chk(debug_fetch_core, 8'hff);
    wr(8'h14, 32'hffffffff);
    rc(8'h14, 32'h1f);
    chk(debug_fetch_reg, 5'h1f);
    wr(8'h10, 0);
    rc(8'h10, 32'h11110005);
    print_verdict;
  end
endmodule
`default_nettype wire
